// ===== inc/bldc_pkg.sv
// Constants, field layouts and carriers of the six-step commutation block.
// Assumes a 32-bit APB bus with byte addresses on paddr.
package bldc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ANGLE = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_BASE = 8'h10;
  localparam logic [7:0] OFS_TIME = 8'h14;
  localparam logic [7:0] OFS_ADC = 8'h18;
  localparam logic [7:0] OFS_DRIVE = 8'h1c;
  localparam logic [2:0] OFS_TABLE_PAGE = 3'h1;
  // Reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [7:0] RST_COEFF = 8'h10;
  // Pending flag positions
  localparam int F_MASK = 0;
  localparam int F_POS = 1;
  localparam int F_WS = 2;
  localparam int F_RO = 3;
  localparam int F_BO = 4;
  localparam int F_ADC = 5;
  // Encodings
  localparam logic [1:0] TRIG_SW = 2'b00;
  localparam logic [1:0] TRIG_RELOAD = 2'b01;
  localparam logic [1:0] TRIG_POS = 2'b10;
  localparam logic [1:0] SRC_HALL = 2'b00;
  localparam logic [1:0] SRC_CMP = 2'b01;
  localparam logic [1:0] SRC_ADC = 2'b10;
  // Noise filter widths in system clocks
  localparam logic [6:0] FILT_W1 = 7'd8;
  localparam logic [6:0] FILT_W2 = 7'd32;
  localparam logic [6:0] FILT_W3 = 7'd64;
  localparam int ANGLE_SHIFT = 7;
  localparam int COEFF_FRAC = 4;

  typedef struct packed {
    logic [2:0] sel;
    logic [11:0] drv;
  } entry_t;

  typedef struct packed {
    logic [1:0] filt_w;
    logic [1:0] src;
    logic [2:0] psc;
    logic cap_src;
    logic autoload;
    logic reload_en;
    logic base_en;
    logic [1:0] avg;
    logic forced;
    logic [1:0] trig;
  } ctrl_t;

  typedef enum logic {RL_MASK, RL_DELAY} rl_phase_t;
endpackage

// ===== rtl/pos_noise_filter.sv
// Glitch filter for the three position inputs.
// Assumes inputs synchronous to pclk; a change passes once it holds.
`timescale 1ns/1ps
module pos_noise_filter
  import bldc_pkg::*;
#(
  parameter int CH = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [1:0] width_sel,
  input wire logic [CH-1:0] din,
  output logic [CH-1:0] dout
);
  if (CH < 1) begin : g_chk
    $error("pos_noise_filter needs at least one channel");
  end
  logic [6:0] need;
  assign need = (width_sel == 2'd1) ? FILT_W1 :
                (width_sel == 2'd2) ? FILT_W2 : FILT_W3;
  for (genvar i = 0; i < CH; i++) begin : g_ch
    logic [6:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt <= '0;
        dout[i] <= 1'b0;
      end else if (ce) begin
        if (width_sel == 2'd0 || din[i] == dout[i]) begin
          cnt <= '0;
          dout[i] <= din[i];
        end else if (cnt == need - 7'd1) begin
          cnt <= '0;
          dout[i] <= din[i];
        end else begin
          cnt <= cnt + 7'd1;
        end
      end
    end
  end
endmodule

// ===== rtl/interval_averager.sv
// Averages the last 1, 2, 4 or 8 captured intervals.
// Assumes one sample pulse per capture; history starts at zero.
`timescale 1ns/1ps
module interval_averager #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic sample,
  input wire logic [1:0] depth,
  input wire logic [W-1:0] din,
  output logic [W-1:0] avg
);
  if (W < 8) begin : g_chk
    $error("interval_averager width too small");
  end
  logic [W-1:0] hist [0:7];
  logic [W+2:0] sum;
  always_comb begin
    sum = '0;
    for (int i = 0; i < 8; i++) begin
      if (i < (1 << depth)) begin
        sum = sum + (W+3)'(hist[i]);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) hist[i] <= '0;
      avg <= '0;
    end else if (ce) begin
      if (sample) begin
        hist[0] <= din;
        for (int i = 1; i < 8; i++) hist[i] <= hist[i-1];
      end
      avg <= W'(sum >> depth);
    end
  end
endmodule

// ===== rtl/bldc_six_step_commutation.sv
// Six-step BLDC commutation timer with APB register access.
// Assumes position inputs and ADC samples synchronous to pclk.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module bldc_six_step_commutation
  import bldc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int ADC_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] hall_in,
  input wire logic [2:0] cmp_in,
  input wire logic adc_valid,
  input wire logic [ADC_W-1:0] adc_active,
  input wire logic [ADC_W-1:0] adc_floating,
  output logic cmp_enable,
  output logic adc_start,
  output logic [11:0] driver_command_word,
  output logic [2:0] comparator_select
);
  if (CNT_W != 16 || ADC_W < 4 || ADC_W > 15) begin : g_chk
    $error("unsupported counter or ADC width");
  end

  function automatic logic [CNT_W-1:0] scale(input logic [CNT_W-1:0] t,
                                              input logic [6:0] ang);
    logic [CNT_W+6:0] p;
    p = (CNT_W+7)'(t) * (CNT_W+7)'(ang);
    return CNT_W'(p >> ANGLE_SHIFT);
  endfunction

  function automatic logic edge_hit(input logic [2:0] s,
                                    input logic [2:0] c,
                                    input logic [2:0] p);
    unique case (s)
      3'd1: return c[0] & ~p[0];
      3'd2: return ~c[2] & p[2];
      3'd3: return c[1] & ~p[1];
      3'd4: return ~c[0] & p[0];
      3'd5: return c[2] & ~p[2];
      3'd6: return ~c[1] & p[1];
      3'd7: return |(c ^ p);
      default: return 1'b0;
    endcase
  endfunction

  ctrl_t ctrl;
  logic [6:0] mask_angle;
  logic [6:0] commute_delay_angle;
  logic [7:0] coeff;
  logic [2:0] commutation_state;
  logic [5:0] pending;
  entry_t state_table_entry [1:7];
  logic [CNT_W-1:0] base_counter;
  logic [CNT_W-1:0] base_limit;
  logic [CNT_W-1:0] interval_capture;
  logic [CNT_W-1:0] filtered_base_time;
  logic [CNT_W-1:0] reload_cnt;
  logic [CNT_W-1:0] reload_limit;
  rl_phase_t rl_phase;
  logic masking;
  logic zc_seen;
  logic sw_xfer;
  logic [6:0] psc_cnt;
  logic [2:0] pos_filt;
  logic [2:0] pos_prev;
  logic adc_sign;
  logic adc_have;
  logic [16:0] adc_pos_result;

  // APB decode
  wire wr = psel & penable & pwrite & ce;
  wire table_hit = (paddr[7:5] == OFS_TABLE_PAGE) && (paddr[4:2] != 3'd0);
  wire [2:0] tidx = paddr[4:2];
  wire mapped = table_hit || paddr == OFS_CTRL || paddr == OFS_ANGLE ||
                paddr == OFS_STATE || paddr == OFS_FLAGS ||
                paddr == OFS_BASE || paddr == OFS_TIME ||
                paddr == OFS_ADC || paddr == OFS_DRIVE;
  wire wr_ctrl = wr && paddr == OFS_CTRL;
  wire wr_angle = wr && paddr == OFS_ANGLE;
  wire wr_state = wr && paddr == OFS_STATE;
  wire wr_flags = wr && paddr == OFS_FLAGS;
  wire wr_base = wr && paddr == OFS_BASE;
  assign pready = ce;
  assign pslverr = psel & penable & ~mapped;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (table_hit) rd_mux = 32'(state_table_entry[tidx]);
    unique case (paddr)
      OFS_CTRL: rd_mux = 32'(ctrl);
      OFS_ANGLE: rd_mux = {8'h00, coeff, 1'b0, commute_delay_angle,
                           1'b0, mask_angle};
      OFS_STATE: rd_mux = {29'h0, commutation_state};
      OFS_FLAGS: rd_mux = {26'h0, pending};
      OFS_BASE: rd_mux = {base_counter, base_limit};
      OFS_TIME: rd_mux = {interval_capture, filtered_base_time};
      OFS_ADC: rd_mux = {15'h0, adc_pos_result};
      OFS_DRIVE: rd_mux = {17'h0, comparator_select, driver_command_word};
      default: ;
    endcase
  end

  wire [6:0] psc_mask = 7'((8'h01 << ctrl.psc) - 8'h01);
  wire tick = (psc_cnt & psc_mask) == psc_mask;

  wire [2:0] pos_raw = (ctrl.src == SRC_CMP) ? cmp_in : hall_in;
  pos_noise_filter #(.CH(3)) u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .width_sel(ctrl.filt_w),
    .din(pos_raw),
    .dout(pos_filt)
  );

  wire pd_evt = ctrl.src != SRC_ADC && ctrl.src != 2'b11 && !masking &&
                edge_hit(comparator_select, pos_filt, pos_prev);
  wire [ADC_W+7:0] kprod = (ADC_W+8)'(coeff) * (ADC_W+8)'(adc_active);
  wire [16:0] adc_diff = 17'(kprod >> COEFF_FRAC) - 17'(adc_floating);
  wire adc_evt = ctrl.src == SRC_ADC && adc_valid && !masking &&
                 adc_have && adc_diff[16] != adc_sign;
  wire pd_any = pd_evt | adc_evt;

  // a crossing in the window blocks overflow
  wire base_hit = ctrl.base_en & tick & base_counter == base_limit &
                  ~zc_seen;
  wire force_evt = base_hit & ctrl.forced;
  wire ro_evt = ctrl.reload_en & tick & reload_cnt >= reload_limit;
  wire xfer_go = force_evt ||
                 (ctrl.trig == TRIG_SW && sw_xfer) ||
                 (ctrl.trig == TRIG_RELOAD && ro_evt && rl_phase == RL_DELAY) ||
                 (ctrl.trig == TRIG_POS && pd_any);
  wire base_rst = ctrl.cap_src ? pd_any : xfer_go;

  assign cmp_enable = ctrl.src == SRC_CMP && commutation_state != 3'd0;
  assign adc_start = ctrl.src == SRC_ADC && commutation_state != 3'd0;

  interval_averager #(.W(CNT_W)) u_avg (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sample(base_rst),
    .depth(ctrl.avg),
    .din(base_counter),
    .avg(filtered_base_time)
  );

  // pending flags, set wins over clear
  wire [5:0] set_flags = {adc_evt, base_hit, ro_evt, xfer_go,
                          pd_evt, ro_evt && rl_phase == RL_MASK};
  wire [5:0] clr_flags = wr_flags ? ~pwdata[5:0] : 6'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      ctrl <= ctrl_t'(RST_CTRL[$bits(ctrl_t)-1:0]);
      mask_angle <= 7'h00;
      commute_delay_angle <= 7'h00;
      coeff <= RST_COEFF;
      pending <= 6'h00;
      sw_xfer <= 1'b0;
      psc_cnt <= 7'h00;
      pos_prev <= 3'h0;
      adc_sign <= 1'b0;
      adc_have <= 1'b0;
      adc_pos_result <= 17'h0_0000;
    end else if (ce) begin
      if (psel && !penable) prdata <= rd_mux;
      if (wr_ctrl) ctrl <= ctrl_t'(pwdata[$bits(ctrl_t)-1:0]);
      if (pd_any || xfer_go) ctrl.reload_en <= 1'b1;
      else if (ro_evt) ctrl.reload_en <= 1'b0;
      if (wr_angle) begin
        mask_angle <= pwdata[6:0];
        commute_delay_angle <= pwdata[14:8];
        coeff <= pwdata[23:16];
      end
      pending <= (pending & ~clr_flags) | set_flags;
      // state write requests transfer on the next cycle
      sw_xfer <= wr_state;
      psc_cnt <= psc_cnt + 7'h01;
      pos_prev <= pos_filt;
      if (adc_valid && ctrl.src == SRC_ADC) begin
        adc_sign <= adc_diff[16];
        adc_have <= 1'b1;
        adc_pos_result <= adc_diff;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      commutation_state <= 3'd0;
      driver_command_word <= 12'h000;
      comparator_select <= 3'd0;
      for (int i = 1; i < 8; i++) state_table_entry[i] <= '0;
    end else if (ce) begin
      if (wr && table_hit) state_table_entry[tidx] <= entry_t'(pwdata[14:0]);
      if (wr_state) begin
        commutation_state <= pwdata[2:0];
      end else if (xfer_go) begin
        if (commutation_state == 3'd6) commutation_state <= 3'd1;
        else if (commutation_state != 3'd0 && commutation_state != 3'd7)
          commutation_state <= commutation_state + 3'd1;
      end
      if (xfer_go) begin
        if (commutation_state == 3'd0) begin
          driver_command_word <= 12'h000;
          comparator_select <= 3'd0;
        end else begin
          driver_command_word <= state_table_entry[commutation_state].drv;
          comparator_select <= state_table_entry[commutation_state].sel;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_counter <= '0;
      base_limit <= '1;
      interval_capture <= '0;
      zc_seen <= 1'b0;
    end else if (ce) begin
      if (base_rst) interval_capture <= base_counter;
      if (base_rst || force_evt) base_counter <= '0;
      else if (ctrl.base_en && tick) base_counter <= base_counter + 1'b1;
      if (base_rst && ctrl.autoload) base_limit <= filtered_base_time;
      else if (wr_base) base_limit <= pwdata[CNT_W-1:0];
      if (pd_any) zc_seen <= 1'b1;
      else if (xfer_go) zc_seen <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_cnt <= '0;
      reload_limit <= '0;
      rl_phase <= RL_MASK;
      masking <= 1'b0;
    end else if (ce) begin
      if (xfer_go) begin
        reload_cnt <= '0;
        reload_limit <= scale(filtered_base_time, mask_angle);
        rl_phase <= RL_MASK;
        masking <= 1'b1;
      end else if (pd_any) begin
        reload_cnt <= '0;
        reload_limit <= scale(filtered_base_time, commute_delay_angle);
        rl_phase <= RL_DELAY;
      end else if (ro_evt) begin
        reload_cnt <= '0;
        unique case (rl_phase)
          RL_MASK: masking <= 1'b0;
          RL_DELAY: ;
        endcase
      end else if (ctrl.reload_en && tick) begin
        reload_cnt <= reload_cnt + 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_xfer;
    ce && xfer_go && !wr_state;
  endsequence

  AST_WS_FLAG: assert property (s_xfer |=> pending[F_WS])
    else $error("write-sequence flag not set");
  AST_STATE_STEP: assert property ((s_xfer and commutation_state inside
    {[3'd1:3'd5]}) |=> commutation_state == $past(commutation_state) + 3'd1)
    else $error("state did not advance");
  AST_STATE7_HOLD: assert property ((s_xfer and commutation_state == 3'd7)
    |=> commutation_state == 3'd7)
    else $error("state 7 moved");
  AST_OFF: assert property ((s_xfer and commutation_state == 3'd0)
    |=> driver_command_word == 12'h000)
    else $error("state 0 did not drive off");
  AST_FLAG_CLEAR: assert property (ce && wr_flags && !pwdata[F_MASK] &&
    !set_flags[F_MASK] |=> !pending[F_MASK])
    else $error("flag not cleared by zero");
  AST_NO_BO_AFTER_ZC: assert property (zc_seen |-> !base_hit)
    else $error("overflow despite crossing");
  AST_FORCE: assert property (ce && force_evt
    |=> base_counter == '0 && pending[F_WS] && pending[F_BO])
    else $error("forced commutation missing");
  AST_RELOAD_STOP: assert property (ce && ro_evt && !pd_any && !xfer_go
    |=> !ctrl.reload_en && reload_cnt == '0)
    else $error("reload counter kept running");
  AST_MASK_QUIET: assert property (masking |-> !pd_evt && !adc_evt)
    else $error("detection during masking");
  AST_CAPTURE: assert property (ce && base_rst |=> base_counter == '0 &&
    interval_capture == $past(base_counter))
    else $error("interval capture wrong");
endmodule

// ===== testbench/phase_frontend_model.sv
// Behavioural front end: hall sensors, phase comparators and ADC.
// Assumes the bench sets rotor levels and requests each sample.
`timescale 1ns/1ps
module phase_frontend_model
  import bldc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmp_enable,
  input wire logic adc_start,
  input wire logic [2:0] rotor_level,
  input wire logic sample_go,
  input wire logic [11:0] sample_act,
  input wire logic [11:0] sample_flt,
  output logic [2:0] hall_in,
  output logic [2:0] cmp_in,
  output logic adc_valid,
  output logic [11:0] adc_active,
  output logic [11:0] adc_floating
);
  logic [11:0] junk;
  logic [11:0] act_q;
  logic [11:0] flt_q;

  assign hall_in = rotor_level;
  assign cmp_in = cmp_enable ? rotor_level : junk[2:0];
  // Sample buses only meaningful with the valid pulse
  assign adc_active = adc_valid ? act_q : junk;
  assign adc_floating = adc_valid ? flt_q : ~junk;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      junk <= 12'h5a5;
      act_q <= 12'h000;
      flt_q <= 12'h000;
      adc_valid <= 1'b0;
    end else begin
      junk <= ~junk;
      act_q <= sample_act;
      flt_q <= sample_flt;
      adc_valid <= sample_go & adc_start;
    end
  end
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the six-step commutation block.
// Assumes bldc_pkg and the front-end model are compiled first.
`timescale 1ns/1ps
module testbench
  import bldc_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sample_go = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [2:0] rotor_level = 3'h0;
  logic [11:0] sample_act = 12'h0, sample_flt = 12'h0;
  logic pready, pslverr, adc_valid, cmp_enable, adc_start, e;
  logic [2:0] hall_in, cmp_in, comparator_select;
  logic [11:0] adc_active, adc_floating, driver_command_word;
  logic [15:0] dc, dg, av;
  entry_t tab [1:7];
  logic [15:0] cap [0:3];
  int gap [0:3];
  int n_errors = 0;
  int compares = 0;

  bldc_six_step_commutation u_dut (.pclk(pclk), .presetn(presetn),
    .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hall_in(hall_in), .cmp_in(cmp_in),
    .adc_valid(adc_valid), .adc_active(adc_active),
    .adc_floating(adc_floating), .cmp_enable(cmp_enable),
    .adc_start(adc_start), .driver_command_word(driver_command_word),
    .comparator_select(comparator_select));

  phase_frontend_model u_fe (.pclk(pclk), .presetn(presetn),
    .cmp_enable(cmp_enable), .adc_start(adc_start),
    .rotor_level(rotor_level), .sample_go(sample_go),
    .sample_act(sample_act), .sample_flt(sample_flt), .hall_in(hall_in),
    .cmp_in(cmp_in), .adc_valid(adc_valid), .adc_active(adc_active),
    .adc_floating(adc_floating));

  always #12.5 pclk = ~pclk;

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; ends one idle edge after the access
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_errors++;
      final_report();
    end
    @(posedge pclk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic samp(logic [11:0] a, logic [11:0] f);
    sample_act <= a;
    sample_flt <= f;
    sample_go <= 1'b1;
    @(posedge pclk);
    sample_go <= 1'b0;
    tick(4);
  endtask

  // Six-step wrap, state 0 and 7 hold
  function automatic logic [2:0] step(int s);
    return (s == 0 || s == 7) ? 3'(s) : (s == 6) ? 3'd1 : 3'(s + 1);
  endfunction

  initial begin
    void'($urandom(99));
    tick(6);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_CTRL);
    check("ctrl", q, RST_CTRL);
    rd(OFS_ANGLE);
    check("angle", q, {8'h00, RST_COEFF, 16'h0000});
    rd(OFS_BASE);
    check("base", q, 32'h0000_ffff);
    rd(8'h80);
    check("unmapped error", 32'(e), 32'h1);
    check("unmapped data", q, 32'h0);
    for (int i = 1; i < 8; i++) begin
      tab[i] = entry_t'(15'($urandom));
      wr(8'h20 + 8'(4 * i), 32'(tab[i]));
      rd(8'h20 + 8'(4 * i));
      check("table", q, 32'(tab[i]));
    end
    // Software transfer through every state, off state last
    for (int k = 1; k < 9; k++) begin
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_STATE, 32'(k % 8));
      tick(2);
      dc = 16'({comparator_select, driver_command_word});
      check("drive", 32'(dc), k < 8 ? 32'(tab[k]) : 32'h0);
      rd(OFS_STATE);
      check("state", q, 32'(step(k % 8)));
      rd(OFS_FLAGS);
      if (k < 8) check("write seq", 32'(q[F_WS]), 32'h1);
    end
    wr(OFS_STATE, 32'h1);
    wr(OFS_FLAGS, 32'hffff_ffff);
    rd(OFS_FLAGS);
    check("flag kept", 32'(q[F_WS]), 32'h1);
    wr(OFS_FLAGS, 32'hffff_fffb);
    rd(OFS_FLAGS);
    check("flag cleared", 32'(q[F_WS]), 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL, 32'(s) << 12);
      check("cmp enable", 32'(cmp_enable), 32'(s == 1));
      check("adc start", 32'(adc_start), 32'(s == 2));
    end
    // Intervals between write events, two-sample average
    wr(OFS_CTRL, 32'h0000_0028);
    for (int i = 0; i < 4; i++) begin
      gap[i] = 10 + int'($urandom_range(60));
      wr(OFS_STATE, 32'h1);
      tick(2);
      rd(OFS_TIME);
      cap[i] = q[31:16];
      if (i >= 2) begin
        dc = cap[i] - cap[i-1];
        dg = 16'(gap[i-1] - gap[i-2]);
        av = 16'((17'(cap[i]) + 17'(cap[i-1])) >> 1);
        check("interval", 32'(dc), 32'(dg));
        check("average", 32'(q[15:0]), 32'(av));
      end
      tick(gap[i]);
    end
    // Limit reached without crossing, forcing off then on
    wr(OFS_BASE, 32'h0000_0020);
    for (int f = 0; f < 2; f++) begin
      wr(OFS_CTRL, f ? 32'h0000_0024 : 32'h0000_0020);
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_STATE, 32'h2);
      tick(45);
      rd(OFS_FLAGS);
      check("overflow", 32'(q[F_BO]), 32'h1);
      check("mask end", 32'(q[F_MASK]), 32'h1);
      rd(OFS_STATE);
      check("forced state", q, f ? 32'h4 : 32'h3);
    end
    dc = 16'({comparator_select, driver_command_word});
    check("forced drive", 32'(dc), 32'(tab[3]));
    // Filtered hall edge, crossing blocks forcing
    wr(8'h24, 32'h0000_7000);
    wr(8'h28, 32'h0000_7000);
    wr(OFS_BASE, 32'h0000_0060);
    wr(OFS_CTRL, 32'h0000_4024);
    wr(OFS_FLAGS, 32'h0);
    wr(OFS_STATE, 32'h1);
    rotor_level <= 3'b001;
    tick(4);
    rotor_level <= 3'b000;
    tick(20);
    rd(OFS_FLAGS);
    check("glitch", 32'(q[F_POS]), 32'h0);
    rotor_level <= 3'b001;
    tick(30);
    rd(OFS_FLAGS);
    check("detect", 32'(q[F_POS]), 32'h1);
    tick(80);
    rd(OFS_FLAGS);
    check("no overflow", 32'(q[F_BO]), 32'h0);
    rd(OFS_STATE);
    check("not forced", q, 32'h2);
    // Sign step of the ADC result, then a new coefficient
    wr(OFS_CTRL, 32'h0000_2000);
    wr(OFS_STATE, 32'h1);
    samp(12'd100, 12'd50);
    wr(OFS_FLAGS, 32'h0);
    samp(12'd100, 12'd150);
    rd(OFS_FLAGS);
    check("adc event", 32'(q[F_ADC]), 32'h1);
    rd(OFS_ADC);
    check("adc result", q, 32'h0001_ffce);
    wr(OFS_ANGLE, 32'h0020_0000);
    wr(OFS_FLAGS, 32'h0);
    samp(12'd100, 12'd150);
    rd(OFS_FLAGS);
    check("coeff event", 32'(q[F_ADC]), 32'h1);
    rd(OFS_ADC);
    check("coeff result", q, 32'h0000_0032);
    final_report();
  end

  initial begin
    tick(90000);
    n_errors++;
    final_report();
  end
endmodule
